//--- pkg/timer2_pkg.sv
// What this block does
// - Select bit picks clock divided by twelve or falling external event edges.
// - Mode from clock selects, capture select and run: reload, capture, baud, off.
// - Capture mode without strobe enable is a plain timer setting overflow flag.
// - Capture mode with strobe enable copies count into capture pair on falling strobe.
// - Strobe capture also sets the external flag, which can interrupt.
// - Auto-reload without strobe enable reloads count from pair and flags overflow.
// - Auto-reload with strobe enable also reloads and flags on falling strobe.
// - Overflow flag set on rollover except in baud mode; software clears it.
// - External flag raises the interrupt when enabled; only software clears it.
// - Receive clock select routes this timer's overflows to serial receive clock.
// - Transmit clock select routes this timer's overflows to serial transmit clock.
// - Strobe acts only with strobe enable set and no serial clocking.
// - Run bit starts the timer when one and stops it when zero.
// - In baud mode capture select is ignored and overflow always reloads.
package timer2_pkg;
   localparam logic [3:0] addr_control = 4'h0;
   localparam logic [3:0] addr_count_low = 4'h1;
   localparam logic [3:0] addr_count_high = 4'h2;
   localparam logic [3:0] addr_reload_low = 4'h3;
   localparam logic [3:0] addr_reload_high = 4'h4;
   localparam logic [3:0] addr_status = 4'h5;
   localparam logic [3:0] addr_mask = 4'h6;
   localparam int bit_overflow = 7;
   localparam int bit_external = 6;
   localparam int bit_rx_clock = 5;
   localparam int bit_tx_clock = 4;
   localparam int bit_ext_enable = 3;
   localparam int bit_run = 2;
   localparam int bit_counter = 1;
   localparam int bit_capture = 0;
   localparam logic [7:0] control_reset = 8'h00;
   localparam logic [15:0] count_reset = 16'h0000;
   localparam logic [1:0] mask_reset = 2'h0;
   localparam int prescale_ratio = 12;
   localparam logic [3:0] prescale_last = 4'(prescale_ratio - 1);
   typedef enum logic [1:0] {
      mode_off = 2'b00,
      mode_reload = 2'b01,
      mode_capture = 2'b11,
      mode_baud = 2'b10
   } mode_t;
endpackage

//--- src/timer2_edge.sv
`timescale 1ns/1ps
// Two-stage synchroniser plus falling-edge pulse
module timer2_edge (
   input wire logic clk,
   input wire logic rst,
   input wire logic pin,
   output logic fall
);
   logic meta, sync, last;
   logic next_fall;
   always_comb begin
      next_fall = last & ~sync;
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         meta <= 1'b1;
         sync <= 1'b1;
         last <= 1'b1;
         fall <= 1'b0;
      end else begin
         meta <= pin;
         sync <= meta;
         last <= sync;
         fall <= next_fall;
      end
   end
endmodule

//--- src/timer2_prescale.sv
`timescale 1ns/1ps
// One tick every twelve clocks, held at zero while stopped
module timer2_prescale
   import timer2_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic run,
   output logic tick
);
   logic [3:0] count, next_count;
   logic next_tick;
   always_comb begin
      next_tick = 1'b0;
      next_count = 4'h0;
      if (run) begin
         if (count == prescale_last) begin
            next_tick = 1'b1;
         end else begin
            next_count = count + 4'h1;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         count <= 4'h0;
         tick <= 1'b0;
      end else begin
         count <= next_count;
         tick <= next_tick;
      end
   end
endmodule

//--- src/timer2.sv
`timescale 1ns/1ps
module timer2
   import timer2_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic event_pin,
   input wire logic external_strobe_pin,
   input wire logic timer1_overflow,
   output logic rx_baud_tick,
   output logic tx_baud_tick,
   output logic irq
);
   import timer2_pkg::*;

   // ************************************
   // Control, count and reload state
   // ************************************
   logic [7:0] control, next_control;
   logic [15:0] count, next_count;
   logic [15:0] reload, next_reload;
   logic [1:0] mask, next_mask;
   logic [7:0] next_rdata;
   logic next_rx, next_tx, next_irq;
   logic osc_tick, event_fall, strobe_fall;
   logic step, rollover, strobe_act, do_reload;
   mode_t mode;

   function automatic mode_t decode_mode(input logic [7:0] c);
      if (!c[bit_run]) begin
         return mode_off;
      end else if (c[bit_rx_clock] | c[bit_tx_clock]) begin
         return mode_baud;
      end else if (c[bit_capture]) begin
         return mode_capture;
      end
      return mode_reload;
   endfunction

   timer2_prescale u_prescale (
      .clk(clk),
      .rst(rst),
      .run(control[bit_run] & ~control[bit_counter]),
      .tick(osc_tick)
   );
   timer2_edge u_event (
      .clk(clk),
      .rst(rst),
      .pin(event_pin),
      .fall(event_fall)
   );
   timer2_edge u_strobe (
      .clk(clk),
      .rst(rst),
      .pin(external_strobe_pin),
      .fall(strobe_fall)
   );

   // ************************************
   // Counting, capture and reload
   // ************************************
   always_comb begin
      mode = decode_mode(control);
      step = (mode != mode_off) & (control[bit_counter] ? event_fall : osc_tick);
      rollover = step & (count == 16'hffff);
      // Strobe is dead while the timer clocks the serial port
      strobe_act = strobe_fall & control[bit_ext_enable] & (mode == mode_capture | mode == mode_reload);
      // Baud mode ignores capture select and always reloads
      do_reload = (rollover & (mode == mode_reload | mode == mode_baud))
         | (strobe_act & mode == mode_reload);
      next_count = count;
      if (do_reload) begin
         next_count = reload;
      end else if (step) begin
         next_count = count + 16'h0001;
      end
      next_reload = reload;
      if (strobe_act & mode == mode_capture) begin
         next_reload = count;
      end
      next_control = control;
      next_mask = mask;
      if (wr) begin
         unique case (addr)
            addr_control: next_control = wdata;
            addr_count_low: next_count[7:0] = wdata;
            addr_count_high: next_count[15:8] = wdata;
            addr_reload_low: next_reload[7:0] = wdata;
            addr_reload_high: next_reload[15:8] = wdata;
            addr_status: begin
               // Write one clears
               if (wdata[bit_overflow]) next_control[bit_overflow] = 1'b0;
               if (wdata[bit_external]) next_control[bit_external] = 1'b0;
            end
            addr_mask: next_mask = wdata[1:0];
            default: next_mask = mask;
         endcase
      end
      // Hardware set wins over a software clear in the same cycle
      if (rollover & mode != mode_baud) begin
         next_control[bit_overflow] = 1'b1;
      end
      if (strobe_act) begin
         next_control[bit_external] = 1'b1;
      end
      next_rx = rollover & control[bit_rx_clock]
         | ~control[bit_rx_clock] & timer1_overflow;
      next_tx = rollover & control[bit_tx_clock]
         | ~control[bit_tx_clock] & timer1_overflow;
      next_irq = (next_control[bit_overflow] & next_mask[1])
         | (next_control[bit_external] & next_mask[0]);
      unique case (addr)
         addr_control, addr_status: next_rdata = control;
         addr_count_low: next_rdata = count[7:0];
         addr_count_high: next_rdata = count[15:8];
         addr_reload_low: next_rdata = reload[7:0];
         addr_reload_high: next_rdata = reload[15:8];
         addr_mask: next_rdata = {6'h00, mask};
         default: next_rdata = 8'h00;
      endcase
      if (!rd) begin
         next_rdata = 8'h00;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         control <= control_reset;
         count <= count_reset;
         reload <= count_reset;
         mask <= mask_reset;
         rdata <= 8'h00;
         rx_baud_tick <= 1'b0;
         tx_baud_tick <= 1'b0;
         irq <= 1'b0;
      end else begin
         control <= next_control;
         count <= next_count;
         reload <= next_reload;
         mask <= next_mask;
         rdata <= next_rdata;
         rx_baud_tick <= next_rx;
         tx_baud_tick <= next_tx;
         irq <= next_irq;
      end
   end

   // ************************************
   // Checks
   // ************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   ovf_flag_set_a: assert property (rollover && mode != mode_baud |=> control[bit_overflow])
      else $error("overflow flag not set");
   baud_no_flag_a: assert property (rollover && mode == mode_baud && !control[bit_overflow]
      && !(wr && addr == addr_control) |=> !control[bit_overflow])
      else $error("overflow flag set in baud mode");
   reload_load_a: assert property (do_reload && !wr |=> count == $past(reload))
      else $error("reload missing");
   capture_copy_a: assert property (strobe_act && mode == mode_capture && !wr |=> reload == $past(count))
      else $error("capture missing");
   ext_flag_a: assert property (strobe_act |=> control[bit_external])
      else $error("external flag not set");
   strobe_ignored_a: assert property (strobe_fall && !control[bit_ext_enable] && !control[bit_external]
      && !wr |=> !control[bit_external])
      else $error("strobe not ignored");
   stopped_hold_a: assert property (!control[bit_run] && !wr |=> count == $past(count))
      else $error("count moved while stopped");
   rx_source_a: assert property (rollover && control[bit_rx_clock] |=> rx_baud_tick)
      else $error("receive tick missing");
   tx_source_a: assert property (!control[bit_tx_clock] && timer1_overflow |=> tx_baud_tick)
      else $error("transmit tick missing");
   irq_level_a: assert property (control[bit_external] && mask[0] |-> ##[0:1] irq)
      else $error("interrupt missing");
   cover_capture: cover property (strobe_act && mode == mode_capture);
   cover_reload: cover property (rollover && mode == mode_reload);
   cover_baud: cover property (rollover && mode == mode_baud);
   cover_irq: cover property (irq);
endmodule

//--- bench/timer2_partner.sv
`timescale 1ns/1ps
// ***
// Far side: event pins, timer 1 and serial port
// ***
module timer2_partner (
   input wire logic clk,
   input wire logic rx_baud_tick,
   input wire logic tx_baud_tick,
   output logic event_pin,
   output logic external_strobe_pin,
   output logic timer1_overflow
);
   int rx_count = 0;
   int tx_count = 0;
   int t1_div = 0;
   initial begin
      event_pin = 1'b1;
      external_strobe_pin = 1'b1;
      timer1_overflow = 1'b0;
   end
   // Stand-in for timer 1: one overflow every 16 clocks
   always @(posedge clk) begin
      t1_div <= (t1_div + 1) % 16;
      timer1_overflow <= (t1_div == 15);
      rx_count <= rx_count + int'(rx_baud_tick);
      tx_count <= tx_count + int'(tx_baud_tick);
   end
   // Six clocks per level, so the synchroniser never misses an edge
   task automatic fall(input bit strobe);
      @(posedge clk);
      if (strobe) external_strobe_pin <= 1'b0;
      else event_pin <= 1'b0;
      repeat (6) @(posedge clk);
      external_strobe_pin <= 1'b1;
      event_pin <= 1'b1;
      repeat (6) @(posedge clk);
   endtask
endmodule

//--- bench/tb_top.sv
`timescale 1ns/1ps
// ***
// Self-checking bench
// ***
module tb_top;
   import timer2_pkg::*;
   logic clk, rst, wr, rd;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, d;
   logic rx_baud_tick, tx_baud_tick, irq, event_pin, external_strobe_pin, timer1_overflow;
   logic [15:0] seed = 16'h0035, v, exp_count, exp_reload;
   int n_fail = 0, tests_run = 0, n, i, r0, t0;
   always #4 clk = ~clk;
   timer2 DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .event_pin(event_pin), .external_strobe_pin(external_strobe_pin), .timer1_overflow(timer1_overflow),
      .rx_baud_tick(rx_baud_tick), .tx_baud_tick(tx_baud_tick), .irq(irq));
   timer2_partner far_end (.clk(clk), .rx_baud_tick(rx_baud_tick), .tx_baud_tick(tx_baud_tick),
      .event_pin(event_pin), .external_strobe_pin(external_strobe_pin), .timer1_overflow(timer1_overflow));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk(input logic [15:0] seen, input logic [15:0] expected);
      tests_run++;
      if (seen !== expected) begin
         n_fail++;
         $display("ERROR %0t seen %h expected %h", $time, seen, expected);
      end
   endtask
   task automatic tally_and_finish;
      $display("Checks %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] x);
      @(posedge clk);
      addr <= a;
      wdata <= x;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [7:0] x);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      // Read data stand in the cycle after the strobe; taken at its closing edge
      @(posedge clk);
      x = rdata;
   endtask
   task automatic set16(input logic [3:0] a, input logic [15:0] x);
      wr_reg(a, x[7:0]);
      wr_reg(4'(a + 1), x[15:8]);
   endtask
   task automatic get16(input logic [3:0] a, output logic [15:0] x);
      rd_reg(a, x[7:0]);
      rd_reg(4'(a + 1), x[15:8]);
   endtask
   // Bounded wait; running out is a mismatch
   task automatic wait_irq(input logic lvl);
      for (i = 0; i < 400 && irq !== lvl; i++) @(posedge clk);
      if (irq !== lvl) begin
         n_fail++;
         tally_and_finish;
      end
   endtask
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 4'h0;
      wdata = 8'h00;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      for (int a = 0; a < 8; a++) begin
         rd_reg(4'(a), d);
         chk(16'(d), 16'h0000);
      end
      // Counter mode counts event edges, stops with run clear
      n = int'(seed % 16'h0008) + 1;
      wr_reg(addr_control, 8'h06);
      repeat (n) far_end.fall(1'b0);
      wr_reg(addr_control, 8'h00);
      far_end.fall(1'b0);
      get16(addr_count_low, v);
      chk(v, 16'(n));
      // Capture of a frozen random count
      seed = lfsr(seed);
      exp_count = seed;
      set16(addr_count_low, exp_count);
      wr_reg(addr_control, 8'h0f);
      far_end.fall(1'b1);
      get16(addr_reload_low, v);
      chk(v, exp_count);
      rd_reg(addr_control, d);
      chk(16'(d[7:6]), 16'h0001);
      wr_reg(addr_mask, 8'h01);
      wait_irq(1'b1);
      wr_reg(addr_status, 8'h40);
      wait_irq(1'b0);
      // Strobe ignored without external enable
      seed = lfsr(seed);
      set16(addr_count_low, seed);
      wr_reg(addr_control, 8'h07);
      far_end.fall(1'b1);
      get16(addr_reload_low, v);
      chk(v, exp_count);
      rd_reg(addr_control, d);
      chk(16'(d[6]), 16'h0000);
      // Auto-reload on rollover, overflow interrupt
      exp_reload = 16'hfff0;
      set16(addr_reload_low, exp_reload);
      set16(addr_count_low, 16'hfffe);
      wr_reg(addr_mask, 8'h02);
      wr_reg(addr_control, 8'h04);
      wait_irq(1'b1);
      wr_reg(addr_control, 8'h00);
      get16(addr_count_low, v);
      chk(16'(v[15:8]), 16'(exp_reload[15:8]));
      wait_irq(1'b0);
      // Strobe forces reload; external flag masked off
      seed = lfsr(seed);
      set16(addr_count_low, seed & 16'h7fff);
      wr_reg(addr_control, 8'h0e);
      far_end.fall(1'b1);
      get16(addr_count_low, v);
      chk(v, exp_reload);
      rd_reg(addr_control, d);
      chk(16'(d[7:6]), 16'h0001);
      chk(16'(irq), 16'h0000);
      // Baud mode: strobe ignored, no overflow flag, ticks every 24 clocks; then transmit ticks from timer 1 every 16 clocks
      set16(addr_reload_low, 16'hfffe);
      // Start near rollover so the window holds only two-tick periods
      set16(addr_count_low, 16'hfffe);
      wr_reg(addr_control, 8'h3c);
      far_end.fall(1'b1);
      r0 = far_end.rx_count;
      t0 = far_end.tx_count;
      repeat (240) @(posedge clk);
      chk(16'(far_end.rx_count - r0 inside {[9:11]}), 16'h0001);
      chk(16'(far_end.tx_count - t0 inside {[9:11]}), 16'h0001);
      rd_reg(addr_control, d);
      chk(16'(d[7:6]), 16'h0000);
      wr_reg(addr_control, 8'h24);
      t0 = far_end.tx_count;
      repeat (240) @(posedge clk);
      chk(16'(far_end.tx_count - t0 inside {[14:16]}), 16'h0001);
      tally_and_finish;
   end
endmodule
